// ==== verilog/mftc_pkg.sv ====
// Purpose: shared types and constants of the memory fault and translation-control block
// Assumes: 32-bit effective addresses, architectural bit 0 is the most significant bit
// Notes:   cause bit positions are given as little-endian vector indices
package mftc_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD, OP_STORE, OP_ZERO_BLOCK, OP_LOAD_RESERVE, OP_STORE_COND,
    OP_EXT_IN, OP_EXT_OUT, OP_FP_LOAD, OP_FP_STORE, OP_LOAD_MULT, OP_STORE_MULT,
    OP_LOAD_STR_IMM, OP_LOAD_STR_IDX, OP_STORE_STR_IMM, OP_STORE_STR_IDX,
    OP_TO_SEG, OP_TO_SEG_IND, OP_FROM_SEG, OP_FROM_SEG_IND,
    OP_TO_SPR, OP_FROM_SPR, OP_TLB_INV_ENTRY, OP_TLB_SYNC, OP_TLB_INV_ALL
  } mftc_op_e;

  typedef enum logic [2:0] {
    FLT_NONE, FLT_ALIGN, FLT_DATA_STORAGE, FLT_ILLEGAL, FLT_PRIV
  } mftc_fault_e;

  typedef struct packed {
    logic        valid;
    mftc_op_e    op;
    logic [31:0] ea;
    logic [31:0] src;
    logic [3:0]  seg_idx;
    logic [4:0]  spr_idx;
    logic [31:0] iaddr;
    logic        supervisor;
    logic        xlate_en;
    logic        write_through;
    logic        cache_inhibit;
  } mftc_req_s;

  typedef struct packed {
    logic        valid;
    mftc_fault_e fault;
    logic [31:0] cause;
    logic [31:0] iaddr;
    logic [31:0] rd;
    logic        page_xlate;
  } mftc_rsp_s;

  typedef struct packed {
    logic       valid;
    logic       ibuf;
    logic [5:0] index;
    logic       way;
  } mftc_fill_s;

  // register map, byte addresses
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_MASK   = 8'h04;
  localparam logic [7:0] ADR_CTRL   = 8'h08;
  localparam logic [7:0] ADR_CAUSE  = 8'h0c;
  localparam logic [7:0] ADR_FADDR  = 8'h10;
  localparam logic [7:0] ADR_STATE  = 8'h14;

  // status / mask bits
  localparam int ST_ALIGN = 0;
  localparam int ST_DSI   = 1;
  localparam int ST_ILL   = 2;
  localparam int ST_PRIV  = 3;
  localparam int ST_SYNC  = 4;
  localparam int ST_W     = 5;

  // control bits
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_REV    = 1;

  localparam int CAUSE_DSTORE = 26;
  localparam int CAUSE_EXTDIS = 20;
  localparam int SEG_T_BIT    = 31;
  localparam int EA_IDX_HI    = 17;
  localparam int EA_IDX_LO    = 12;
  localparam int SRC_SEG_HI   = 31;
  localparam int SRC_SEG_LO   = 28;

  localparam int N_SEG   = 16;
  localparam int N_BAT   = 16;
  localparam int N_SETS  = 64;
  localparam int N_WAYS  = 2;
  localparam logic [4:0] SPR_PTB = 5'h10;

  localparam logic [31:0] ZERO32 = 32'h0000_0000;

endpackage

// ==== verilog/mftc_top.sv ====
// Purpose: memory fault classification and translation-control operations for the load/store pipeline
// Assumes: one request per cycle while ready, answer on the following cycle; classic Wishbone config port
// Notes:   table search, block translation and history bits live elsewhere; only valid bits of the buffers
// Notes on behaviour
// [RULE1] zero-block to write-through/inhibited memory faults alignment
// [RULE2] reservation/external ops on direct-store: storage fault, cause 5
// [RULE3] fp access to direct-store: storage fault, cause 5
// [RULE4] external ops with access disabled: cause 11 (code raises it only with translation enabled)
// [RULE5] multiple/string ops in reversed order fault alignment
// [RULE6] translated misaligned word operands fault alignment
// [RULE7] direct-store error exception never produced
// [RULE8] invalidate-all decodes as illegal instruction
// [RULE9] segment moves by immediate or source bits 0-3 (code indexes the indirect move to a segment by address bits 0-3)
// [RULE10] entry invalidate clears four entries, both buffers
// [RULE11] software finishes page accesses before invalidate
// [RULE12] barrier stalls while sync stall input high
// [RULE13] sixteen 32-bit segments, bit 0 selects meaning
// [RULE14] sixteen 32-bit block-translation registers via special moves
// [RULE15] 32-bit page table base via special moves
// [RULE16] translation registers supervisor-only
// [RULE17] segment direct-store bit zero selects paging
// [RULE18] fault type, cause, address reported in one cycle
`timescale 1ns/1ps

module mftc_top
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire mftc_pkg::mftc_req_s    req_i,
  output logic                        req_ready_o,
  output mftc_pkg::mftc_rsp_s         rsp_o,
  input  wire mftc_pkg::mftc_fill_s   fill_i,
  input  wire logic                   tlb_sync_stall_i,
  output logic                        stall_o,
  output logic [63:0][1:0]            itlb_valid_o,
  output logic [63:0][1:0]            dtlb_valid_o,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        irq_o
);

  typedef struct packed {
    logic [15:0][31:0]       seg;
    logic [15:0][31:0]       bat;
    logic [31:0]             ptb;
    logic [63:0][1:0]        itv;
    logic [63:0][1:0]        dtv;
    logic [1:0]              ctrl;
    logic [4:0]              status;
    logic [4:0]              mask;
    logic                    ack;
    logic [31:0]             rdata;
    mftc_pkg::mftc_rsp_s     rsp;
    logic                    sync_pend;
    logic [31:0]             last_cause;
    logic [31:0]             last_faddr;
  } mftc_state_s;

  mftc_state_s s_q;
  mftc_state_s s_d;

  logic        take;
  logic        wb_req;
  logic        rd_status;
  logic        is_ds_class;
  logic        is_word_op;
  logic        is_multi;
  logic        is_ext;
  logic        is_priv_op;
  logic        seg_t;
  logic        ext_en;
  logic        rev_order;
  logic [3:0]  seg_sel;
  logic [5:0]  ea_idx;
  logic [4:0]  events;
  mftc_pkg::mftc_fault_e fault;
  logic [31:0] cause;
  logic [31:0] rd_val;

  // stall only after a barrier has been taken; release follows the input at once
  assign stall_o     = s_q.sync_pend & tlb_sync_stall_i; // [RULE12]
  assign req_ready_o = ~stall_o;
  assign take        = req_i.valid & req_ready_o;
  assign wb_req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign rd_status   = wb_req & ~wb_we_i & (wb_adr_i == mftc_pkg::ADR_STATUS);

  assign ext_en    = s_q.ctrl[mftc_pkg::CTRL_EXT_EN];
  assign rev_order = s_q.ctrl[mftc_pkg::CTRL_REV];
  assign seg_sel   = req_i.ea[mftc_pkg::SRC_SEG_HI:mftc_pkg::SRC_SEG_LO];
  assign seg_t     = s_q.seg[seg_sel][mftc_pkg::SEG_T_BIT];
  assign ea_idx    = req_i.ea[mftc_pkg::EA_IDX_HI:mftc_pkg::EA_IDX_LO];

  always_comb
  begin
    is_ext = (req_i.op == mftc_pkg::OP_EXT_IN) | (req_i.op == mftc_pkg::OP_EXT_OUT);
    is_multi = (req_i.op == mftc_pkg::OP_LOAD_MULT) | (req_i.op == mftc_pkg::OP_STORE_MULT)
             | (req_i.op == mftc_pkg::OP_LOAD_STR_IMM) | (req_i.op == mftc_pkg::OP_LOAD_STR_IDX)
             | (req_i.op == mftc_pkg::OP_STORE_STR_IMM) | (req_i.op == mftc_pkg::OP_STORE_STR_IDX);
    // string ops take byte addresses, so only the word forms join the alignment check
    is_word_op = (req_i.op == mftc_pkg::OP_FP_LOAD) | (req_i.op == mftc_pkg::OP_FP_STORE)
               | (req_i.op == mftc_pkg::OP_LOAD_MULT) | (req_i.op == mftc_pkg::OP_STORE_MULT)
               | (req_i.op == mftc_pkg::OP_LOAD_RESERVE) | (req_i.op == mftc_pkg::OP_STORE_COND) | is_ext;
    is_ds_class = (req_i.op == mftc_pkg::OP_LOAD_RESERVE) | (req_i.op == mftc_pkg::OP_STORE_COND)
                | is_ext | (req_i.op == mftc_pkg::OP_FP_LOAD) | (req_i.op == mftc_pkg::OP_FP_STORE)
                | (req_i.op == mftc_pkg::OP_LOAD) | (req_i.op == mftc_pkg::OP_STORE)
                | (req_i.op == mftc_pkg::OP_ZERO_BLOCK) | is_multi;
    is_priv_op = (req_i.op == mftc_pkg::OP_TO_SEG) | (req_i.op == mftc_pkg::OP_TO_SEG_IND)
               | (req_i.op == mftc_pkg::OP_FROM_SEG) | (req_i.op == mftc_pkg::OP_FROM_SEG_IND)
               | (req_i.op == mftc_pkg::OP_TO_SPR) | (req_i.op == mftc_pkg::OP_FROM_SPR);
  end

  // classification; alignment outranks storage faults, and no direct-store error kind exists
  always_comb
  begin
    fault = mftc_pkg::FLT_NONE;
    cause = mftc_pkg::ZERO32;
    if (req_i.op == mftc_pkg::OP_TLB_INV_ALL)
      fault = mftc_pkg::FLT_ILLEGAL; // [RULE8]
    else if (is_priv_op & ~req_i.supervisor)
      fault = mftc_pkg::FLT_PRIV; // [RULE16]
    else if ((req_i.op == mftc_pkg::OP_ZERO_BLOCK) & (req_i.write_through | req_i.cache_inhibit))
      fault = mftc_pkg::FLT_ALIGN; // [RULE1]
    else if (is_multi & rev_order)
      fault = mftc_pkg::FLT_ALIGN; // [RULE5]
    else if (req_i.xlate_en & is_word_op & (req_i.ea[1:0] != 2'b00))
      fault = mftc_pkg::FLT_ALIGN; // [RULE6]
    else if (req_i.xlate_en & ((is_ext & ~ext_en) | (is_ds_class & seg_t)))
    begin
      fault = mftc_pkg::FLT_DATA_STORAGE; // [RULE7]
      cause[mftc_pkg::CAUSE_EXTDIS] = is_ext & ~ext_en; // [RULE4]
      cause[mftc_pkg::CAUSE_DSTORE] = is_ds_class & seg_t; // [RULE2] [RULE3]
    end
  end

  always_comb
  begin
    rd_val = mftc_pkg::ZERO32;
    unique case (req_i.op)
      mftc_pkg::OP_FROM_SEG:     rd_val = s_q.seg[req_i.seg_idx]; // [RULE9]
      mftc_pkg::OP_FROM_SEG_IND: rd_val = s_q.seg[req_i.src[mftc_pkg::SRC_SEG_HI:mftc_pkg::SRC_SEG_LO]]; // [RULE9]
      mftc_pkg::OP_FROM_SPR:
        if (req_i.spr_idx == mftc_pkg::SPR_PTB)
          rd_val = s_q.ptb; // [RULE15]
        else if (req_i.spr_idx[4] == 1'b0)
          rd_val = s_q.bat[req_i.spr_idx[3:0]]; // [RULE14]
      default:                   rd_val = mftc_pkg::ZERO32;
    endcase
  end

  always_comb
  begin
    events = '0;
    events[mftc_pkg::ST_ALIGN] = take & (fault == mftc_pkg::FLT_ALIGN);
    events[mftc_pkg::ST_DSI]   = take & (fault == mftc_pkg::FLT_DATA_STORAGE);
    events[mftc_pkg::ST_ILL]   = take & (fault == mftc_pkg::FLT_ILLEGAL);
    events[mftc_pkg::ST_PRIV]  = take & (fault == mftc_pkg::FLT_PRIV);
    events[mftc_pkg::ST_SYNC]  = s_q.sync_pend & tlb_sync_stall_i & ~s_q.status[mftc_pkg::ST_SYNC];
  end

  always_comb
  begin
    s_d = s_q;
    s_d.ack = wb_req;
    s_d.rsp.valid = take;
    if (take)
    begin
      // result, cause and faulting address leave together on the next cycle
      s_d.rsp.fault      = fault; // [RULE18]
      s_d.rsp.cause      = cause;
      s_d.rsp.iaddr      = req_i.iaddr;
      s_d.rsp.rd         = (fault == mftc_pkg::FLT_NONE) ? rd_val : mftc_pkg::ZERO32;
      s_d.rsp.page_xlate = req_i.xlate_en & is_ds_class & ~seg_t; // [RULE17] [RULE13]
      if (fault != mftc_pkg::FLT_NONE)
      begin
        s_d.last_cause = cause;
        s_d.last_faddr = req_i.iaddr;
      end
      else
      begin
        unique case (req_i.op)
          mftc_pkg::OP_TO_SEG:     s_d.seg[req_i.seg_idx] = req_i.src; // [RULE9]
          mftc_pkg::OP_TO_SEG_IND: s_d.seg[req_i.ea[mftc_pkg::SRC_SEG_HI:mftc_pkg::SRC_SEG_LO]] = req_i.src;
          mftc_pkg::OP_TO_SPR:
            if (req_i.spr_idx == mftc_pkg::SPR_PTB)
              s_d.ptb = req_i.src; // [RULE15]
            else if (req_i.spr_idx[4] == 1'b0)
              s_d.bat[req_i.spr_idx[3:0]] = req_i.src; // [RULE14]
          mftc_pkg::OP_TLB_INV_ENTRY:
          begin
            // both ways of both buffers at the indexed set; caller has drained the page
            s_d.itv[ea_idx] = 2'b00; // [RULE10] [RULE11]
            s_d.dtv[ea_idx] = 2'b00; // [RULE10]
          end
          mftc_pkg::OP_TLB_SYNC:   s_d.sync_pend = 1'b1; // [RULE12]
          default:                 s_d.sync_pend = s_q.sync_pend;
        endcase
      end
    end
    // a fresh barrier in the releasing cycle must stay pending
    if (s_q.sync_pend & ~tlb_sync_stall_i & ~(take & (req_i.op == mftc_pkg::OP_TLB_SYNC)))
      s_d.sync_pend = 1'b0; // [RULE12]
    // a fill to the very set being invalidated loses; the invalidate is the newer intent
    if (fill_i.valid & ~(take & (req_i.op == mftc_pkg::OP_TLB_INV_ENTRY) & (fill_i.index == ea_idx)))
    begin
      if (fill_i.ibuf)
        s_d.itv[fill_i.index][fill_i.way] = 1'b1;
      else
        s_d.dtv[fill_i.index][fill_i.way] = 1'b1;
    end
    // register port
    s_d.rdata = mftc_pkg::ZERO32;
    if (wb_req & ~wb_we_i)
    begin
      unique case (wb_adr_i)
        mftc_pkg::ADR_STATUS: s_d.rdata = {27'h000_0000, s_q.status};
        mftc_pkg::ADR_MASK:   s_d.rdata = {27'h000_0000, s_q.mask};
        mftc_pkg::ADR_CTRL:   s_d.rdata = {30'h0000_0000, s_q.ctrl};
        mftc_pkg::ADR_CAUSE:  s_d.rdata = s_q.last_cause;
        mftc_pkg::ADR_FADDR:  s_d.rdata = s_q.last_faddr;
        mftc_pkg::ADR_STATE:  s_d.rdata = {30'h0000_0000, stall_o, s_q.sync_pend};
        default:              s_d.rdata = mftc_pkg::ZERO32;
      endcase
    end
    if (wb_req & wb_we_i & wb_sel_i[0])
    begin
      if (wb_adr_i == mftc_pkg::ADR_MASK)
        s_d.mask = wb_dat_i[4:0];
      if (wb_adr_i == mftc_pkg::ADR_CTRL)
        s_d.ctrl = wb_dat_i[1:0];
    end
    // a new event in the reading cycle survives the clear
    s_d.status = (rd_status ? 5'h00 : s_q.status) | events;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rsp_o        = s_q.rsp;
  assign itlb_valid_o = s_q.itv;
  assign dtlb_valid_o = s_q.dtv;
  assign wb_dat_o     = s_q.rdata;
  assign wb_ack_o     = s_q.ack;
  assign irq_o        = |(s_q.status & s_q.mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ZERO_BLOCK_ALIGN: assert property ( // [RULE1]
    take & (req_i.op == mftc_pkg::OP_ZERO_BLOCK) & req_i.supervisor & (req_i.write_through | req_i.cache_inhibit)
    |=> rsp_o.valid & (rsp_o.fault == mftc_pkg::FLT_ALIGN))
    else $error("zero block to inhibited memory not faulted");

  AST_RESERVE_DSTORE: assert property ( // [RULE2]
    take & ((req_i.op == mftc_pkg::OP_LOAD_RESERVE) | (req_i.op == mftc_pkg::OP_STORE_COND)) & req_i.xlate_en
    & seg_t & (req_i.ea[1:0] == 2'b00)
    |=> (rsp_o.fault == mftc_pkg::FLT_DATA_STORAGE) & rsp_o.cause[mftc_pkg::CAUSE_DSTORE])
    else $error("reservation to direct-store without cause 5");

  AST_FP_DSTORE: assert property ( // [RULE3]
    take & (req_i.op == mftc_pkg::OP_FP_LOAD) & req_i.xlate_en & seg_t & (req_i.ea[1:0] == 2'b00)
    |=> rsp_o.cause[mftc_pkg::CAUSE_DSTORE] & ~rsp_o.page_xlate)
    else $error("fp access to direct-store not faulted");

  AST_EXT_DISABLED: assert property ( // [RULE4]
    take & is_ext & req_i.xlate_en & ~ext_en & (req_i.ea[1:0] == 2'b00)
    |=> (rsp_o.fault == mftc_pkg::FLT_DATA_STORAGE) & rsp_o.cause[mftc_pkg::CAUSE_EXTDIS])
    else $error("external op with access disabled missed cause 11");

  AST_MULTI_REVERSED: assert property ( // [RULE5]
    take & is_multi & rev_order |=> rsp_o.fault == mftc_pkg::FLT_ALIGN)
    else $error("multiple or string op in reversed order not faulted");

  AST_MISALIGNED: assert property ( // [RULE6]
    take & is_word_op & req_i.xlate_en & (req_i.ea[1:0] != 2'b00) |=> rsp_o.fault == mftc_pkg::FLT_ALIGN)
    else $error("misaligned word operand not faulted");

  AST_NO_DS_ON_LOADS: assert property ( // [RULE7]
    take & ((req_i.op == mftc_pkg::OP_LOAD) | (req_i.op == mftc_pkg::OP_STORE)) & ~seg_t
    |=> rsp_o.fault == mftc_pkg::FLT_NONE)
    else $error("plain access on paged segment faulted");

  AST_INV_ALL_ILLEGAL: assert property ( // [RULE8]
    take & (req_i.op == mftc_pkg::OP_TLB_INV_ALL) & ~fill_i.valid
    |=> (rsp_o.fault == mftc_pkg::FLT_ILLEGAL) & $stable(itlb_valid_o) & $stable(dtlb_valid_o))
    else $error("invalidate-all was not illegal");

  AST_SEG_ROUNDTRIP: assert property ( // [RULE9]
    take & (req_i.op == mftc_pkg::OP_TO_SEG) & req_i.supervisor
    |=> s_q.seg[$past(req_i.seg_idx)] == $past(req_i.src))
    else $error("segment register write lost");

  AST_INV_ENTRY: assert property ( // [RULE10]
    take & (req_i.op == mftc_pkg::OP_TLB_INV_ENTRY) & ~fill_i.valid
    |=> (itlb_valid_o[$past(ea_idx)] == 2'b00) & (dtlb_valid_o[$past(ea_idx)] == 2'b00))
    else $error("entry invalidate left a valid entry");

  AST_SYNC_STALL: assert property ( // [RULE12]
    take & (req_i.op == mftc_pkg::OP_TLB_SYNC) ##1 tlb_sync_stall_i |-> stall_o & ~req_ready_o)
    else $error("barrier did not stall while input high");

  AST_USER_REFUSED: assert property ( // [RULE16]
    take & is_priv_op & ~req_i.supervisor |=> (rsp_o.fault == mftc_pkg::FLT_PRIV) & $stable(s_q.seg))
    else $error("user access to translation registers allowed");

  AST_REPORT: assert property ( // [RULE18]
    take |=> rsp_o.valid & (rsp_o.iaddr == $past(req_i.iaddr)) ##1 (rsp_o.valid == $past(take)))
    else $error("fault report not one cycle after request");

  COV_DSI: cover property (take & (fault == mftc_pkg::FLT_DATA_STORAGE));
  COV_SYNC_HOLD: cover property (stall_o [*3] ##1 ~stall_o);
  COV_INV: cover property (take & (req_i.op == mftc_pkg::OP_TLB_INV_ENTRY));
  COV_IRQ: cover property ($rose(irq_o));

endmodule

// ==== bench/mftc_pipe_model.sv ====
// Purpose: load/store pipeline model that issues requests to the fault and translation-control block
// Assumes: answer comes one edge after the request is taken
// Notes:   address and operand lines are inverted once released so stale values never look valid
`timescale 1ns/1ps

module mftc_pipe_model
(
  input  wire logic                clk_i,
  input  wire logic                ready_i,
  input  wire mftc_pkg::mftc_rsp_s rsp_i,
  output mftc_pkg::mftc_req_s      req_o
);
  initial req_o = '0;

  // one request in flight: earlier accesses finish before any invalidate is issued
  task automatic issue(input mftc_pkg::mftc_req_s r, output mftc_pkg::mftc_rsp_s got);
    @(posedge clk_i);
    req_o <= r;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    req_o.valid <= 1'b0;
    req_o.ea    <= ~r.ea;
    req_o.src   <= ~r.src;
    @(posedge clk_i);
    got = rsp_i;
  endtask
endmodule

// ==== bench/mftc_top_tb.sv ====
// Purpose: self-checking bench for the fault and translation-control block
// Assumes: pipeline model issues one request at a time; registers over classic Wishbone
// Notes:   status reads clear events, so scenarios that check status read it first
`timescale 1ns/1ps

module mftc_top_tb;
  logic                clk_i, rst_i, stall_in, wb_cyc, wb_stb, wb_we, ready, stall_o, ack, irq;
  logic [7:0]          wb_adr;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_dat, dat_o, v;
  logic [63:0][1:0]    itv, dtv;
  mftc_pkg::mftc_req_s req;
  mftc_pkg::mftc_rsp_s rsp, last;
  mftc_pkg::mftc_fill_s fill;
  int                  fails, n_compared, cycles;

  mftc_top dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .req_ready_o(ready), .rsp_o(rsp), .fill_i(fill),
    .tlb_sync_stall_i(stall_in), .stall_o(stall_o), .itlb_valid_o(itv), .dtlb_valid_o(dtv), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
  mftc_pipe_model pm (.clk_i(clk_i), .ready_i(ready), .rsp_i(rsp), .req_o(req));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("counts: %0d compared, %0d mismatched", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // generous ceiling: the full sequence needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cf(input mftc_pkg::mftc_fault_e e);
    cmp({29'd0, last.fault}, {29'd0, e});
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= wd;
    do @(posedge clk_i); while (ack !== 1'b1);
    v = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    cmp(v, exp);
  endtask

  task automatic run(input mftc_pkg::mftc_op_e op, input logic [31:0] ea, input logic [31:0] src,
                     input logic [4:0] idx, input logic sup, input logic xl, input logic [1:0] wi);
    mftc_pkg::mftc_req_s r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.ea = ea;
    r.src = src;
    r.seg_idx = idx[3:0];
    r.spr_idx = idx;
    r.iaddr = ea ^ 32'h00a5_5a00;
    r.supervisor = sup;
    r.xlate_en = xl;
    r.write_through = wi[1];
    r.cache_inhibit = wi[0];
    pm.issue(r, last);
    cmp({31'd0, last.valid}, 32'h0000_0001);
    cmp(last.iaddr, r.iaddr);
  endtask

  task automatic f(input mftc_pkg::mftc_op_e op, input logic [31:0] ea, input logic xl, input logic [1:0] wi,
                   input mftc_pkg::mftc_fault_e ef, input logic [31:0] ec);
    run(op, ea, 32'h0000_0000, 5'h00, 1'b1, xl, wi);
    cf(ef);
    cmp(last.cause, ec);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++)
      rdchk((i == 6) ? 8'h40 : 8'(i * 4), 32'h0000_0000);
    cmp({30'd0, ready, irq}, 32'h0000_0002);
    $display("reset test done");
  endtask

  task automatic t_seg();
    run(mftc_pkg::OP_TO_SEG, 32'h0000_0000, 32'h1234_5678, 5'h03, 1'b1, 1'b0, 2'b00);
    run(mftc_pkg::OP_FROM_SEG, 32'h0000_0000, 32'h0000_0000, 5'h03, 1'b1, 1'b0, 2'b00);
    cmp(last.rd, 32'h1234_5678);
    run(mftc_pkg::OP_TO_SEG_IND, 32'h5000_0000, 32'h8765_4321, 5'h00, 1'b1, 1'b0, 2'b00);
    run(mftc_pkg::OP_FROM_SEG_IND, 32'h0000_0000, 32'h5000_0000, 5'h00, 1'b1, 1'b0, 2'b00);
    cmp(last.rd, 32'h8765_4321);
    run(mftc_pkg::OP_TO_SEG, 32'h0000_0000, 32'h0000_0000, 5'h03, 1'b0, 1'b0, 2'b00);
    cf(mftc_pkg::FLT_PRIV);
    run(mftc_pkg::OP_FROM_SEG, 32'h0000_0000, 32'h0000_0000, 5'h03, 1'b1, 1'b0, 2'b00);
    cmp(last.rd, 32'h1234_5678);
    $display("segment test done");
  endtask

  task automatic t_spr();
    for (int i = 0; i < 17; i++)
      run(mftc_pkg::OP_TO_SPR, 32'h0000_0000, 32'h5a5a_0000 | 32'(i), 5'(i), 1'b1, 1'b0, 2'b00);
    run(mftc_pkg::OP_TO_SPR, 32'h0000_0000, 32'hffff_ffff, 5'h14, 1'b1, 1'b0, 2'b00);
    for (int i = 0; i < 17; i++)
    begin
      run(mftc_pkg::OP_FROM_SPR, 32'h0000_0000, 32'h0000_0000, 5'(i), 1'b1, 1'b0, 2'b00);
      cmp(last.rd, 32'h5a5a_0000 | 32'(i));
    end
    run(mftc_pkg::OP_FROM_SPR, 32'h0000_0000, 32'h0000_0000, 5'h14, 1'b1, 1'b0, 2'b00);
    cmp(last.rd, 32'h0000_0000);
    run(mftc_pkg::OP_TO_SPR, 32'h0000_0000, 32'h0000_0000, 5'h10, 1'b0, 1'b0, 2'b00);
    cf(mftc_pkg::FLT_PRIV);
    $display("special register test done");
  endtask

  task automatic t_faults();
    wb(1'b1, mftc_pkg::ADR_CTRL, 32'h0000_0000);
    f(mftc_pkg::OP_ZERO_BLOCK, 32'h0000_0000, 1'b0, 2'b10, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    f(mftc_pkg::OP_ZERO_BLOCK, 32'h0000_0000, 1'b0, 2'b01, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    f(mftc_pkg::OP_ZERO_BLOCK, 32'h0000_0000, 1'b0, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    f(mftc_pkg::OP_LOAD_RESERVE, 32'h5000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0400_0000);
    f(mftc_pkg::OP_STORE_COND, 32'h5000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0400_0000);
    f(mftc_pkg::OP_EXT_IN, 32'h5000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0410_0000);
    rdchk(mftc_pkg::ADR_CAUSE, 32'h0410_0000);
    f(mftc_pkg::OP_EXT_OUT, 32'h1000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0010_0000);
    f(mftc_pkg::OP_FP_LOAD, 32'h5000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0400_0000);
    f(mftc_pkg::OP_FP_STORE, 32'h5000_0004, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0400_0000);
    f(mftc_pkg::OP_FP_LOAD, 32'h1000_0002, 1'b1, 2'b00, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    f(mftc_pkg::OP_LOAD_RESERVE, 32'h1000_0001, 1'b1, 2'b00, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    f(mftc_pkg::OP_FP_STORE, 32'h1000_0002, 1'b0, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    f(mftc_pkg::OP_LOAD, 32'h1000_0000, 1'b1, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    cmp({31'd0, last.page_xlate}, 32'h0000_0001);
    f(mftc_pkg::OP_LOAD, 32'h5000_0000, 1'b1, 2'b00, mftc_pkg::FLT_DATA_STORAGE, 32'h0400_0000);
    cmp({31'd0, last.page_xlate}, 32'h0000_0000);
    f(mftc_pkg::OP_TLB_INV_ALL, 32'h0000_5000, 1'b1, 2'b00, mftc_pkg::FLT_ILLEGAL, 32'h0000_0000);
    wb(1'b1, mftc_pkg::ADR_CTRL, 32'h0000_0001);
    f(mftc_pkg::OP_EXT_IN, 32'h1000_0000, 1'b1, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    wb(1'b1, mftc_pkg::ADR_CTRL, 32'h0000_0002);
    for (int i = mftc_pkg::OP_LOAD_MULT; i <= mftc_pkg::OP_STORE_STR_IDX; i++)
      f(mftc_pkg::mftc_op_e'(i), 32'h0000_0000, 1'b0, 2'b00, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    wb(1'b1, mftc_pkg::ADR_CTRL, 32'h0000_0000);
    f(mftc_pkg::OP_LOAD_MULT, 32'h0000_0000, 1'b0, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    $display("fault test done");
  endtask

  task automatic t_inval();
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_i);
      fill <= {1'b1, k[1], (k[2] ? 6'h06 : 6'h05), k[0]};
    end
    @(posedge clk_i);
    fill.valid <= 1'b0;
    @(negedge clk_i);
    cmp({28'd0, itv[5], dtv[5]}, 32'h0000_000f);
    run(mftc_pkg::OP_TLB_INV_ENTRY, 32'h0000_5000, 32'h0000_0000, 5'h00, 1'b1, 1'b1, 2'b00);
    @(negedge clk_i);
    cmp({28'd0, itv[5], dtv[5]}, 32'h0000_0000);
    cmp({28'd0, itv[6], dtv[6]}, 32'h0000_000f);
    $display("invalidate test done");
  endtask

  task automatic t_sync();
    // align, data-storage, illegal and privilege faults all happened since the reset read
    rdchk(mftc_pkg::ADR_STATUS, 32'h0000_000f);
    @(posedge clk_i);
    stall_in <= 1'b1;
    @(negedge clk_i);
    cmp({31'd0, stall_o}, 32'h0000_0000);
    run(mftc_pkg::OP_TLB_SYNC, 32'h0000_0000, 32'h0000_0000, 5'h00, 1'b1, 1'b0, 2'b00);
    repeat (5) @(posedge clk_i);
    cmp({30'd0, stall_o, ready}, 32'h0000_0002);
    rdchk(mftc_pkg::ADR_STATE, 32'h0000_0003);
    rdchk(mftc_pkg::ADR_STATUS, 32'h0000_0010);
    @(posedge clk_i);
    stall_in <= 1'b0;
    @(negedge clk_i);
    cmp({30'd0, stall_o, ready}, 32'h0000_0001);
    f(mftc_pkg::OP_LOAD, 32'h1000_0000, 1'b1, 2'b00, mftc_pkg::FLT_NONE, 32'h0000_0000);
    $display("barrier test done");
  endtask

  task automatic t_irq();
    // the barrier bit comes back after the clearing read while the stall still held
    rdchk(mftc_pkg::ADR_STATUS, 32'h0000_0010);
    wb(1'b1, mftc_pkg::ADR_MASK, 32'hffff_ffff);
    rdchk(mftc_pkg::ADR_MASK, 32'h0000_001f);
    wb(1'b1, mftc_pkg::ADR_MASK, 32'h0000_0001);
    f(mftc_pkg::OP_ZERO_BLOCK, 32'h0000_0040, 1'b0, 2'b10, mftc_pkg::FLT_ALIGN, 32'h0000_0000);
    @(negedge clk_i);
    cmp({31'd0, irq}, 32'h0000_0001);
    rdchk(mftc_pkg::ADR_FADDR, 32'h00a5_5a40);
    wb(1'b1, mftc_pkg::ADR_MASK, 32'h0000_0002);
    @(negedge clk_i);
    cmp({31'd0, irq}, 32'h0000_0000);
    rdchk(mftc_pkg::ADR_STATUS, 32'h0000_0001);
    wb(1'b1, mftc_pkg::ADR_MASK, 32'h0000_0001);
    @(negedge clk_i);
    cmp({31'd0, irq}, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0000_0000);
    $display("interrupt test done");
  endtask

  initial
  begin
    {rst_i, stall_in, wb_cyc, wb_stb, wb_we} = 5'b10000;
    {wb_adr, wb_sel, wb_dat} = '0;
    fill = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_seg();
    t_spr();
    t_faults();
    t_inval();
    t_sync();
    t_irq();
    tally_and_finish();
  end
endmodule
